/* ocfs_pkg.sv */
// Purpose: shared constants, register map and frequency decoders for the output clock selector
// Assumes: 32-bit APB registers, one aligned word each; frequencies carried in kHz
// Notes: tables return 0 kHz for codes that select nothing
package ocfs_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_PRI_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEC_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OUT_CTRL0 = 8'h08; // four words, 08h to 14h
    localparam logic [7:0] ADDR_OUT_ALT = 8'h18;
    localparam logic [7:0] ADDR_MISC_SIX = 8'h1C;
    localparam logic [7:0] ADDR_MISC_SEVEN = 8'h20;
    localparam logic [7:0] ADDR_PRI_STAT = 8'h24;
    localparam logic [7:0] ADDR_SEC_STAT = 8'h28;
    // field positions
    localparam int PRI_FREQ_LSB = 0;
    localparam int LOCK_SEL_BIT = 3;
    localparam int LOCKED_FREQ_LSB = 4;
    localparam int DIGA_STD_BIT = 0;
    localparam int DIGB_STD_BIT = 1;
    localparam int DIGB_ALT_BIT = 2;
    localparam int DIGA_FREQ_LSB = 0;
    localparam int DIGB_FREQ_LSB = 2;
    localparam int SEC_ON_BIT = 31;
    localparam int SEC_LOCK_BIT = 30;
    // reset value of every writable field
    localparam logic [7:0] RST_CFG = 8'h00;
    // sizes
    localparam int NUM_OUT = 7;
    localparam int KHZ_W = 19;
    localparam int DIV_W = 7;
    localparam int DFS_SHIFT = 2; // synthesis stage runs at a quarter of the apll
    localparam logic [KHZ_W-1:0] SECOND_PRI_KHZ = 19'h4C4B4; // 312500 kHz, fixed

    // output clock sources
    typedef enum logic [3:0] {
        SRC_OFF = 4'h0, SRC_2K = 4'h1, SRC_8K = 4'h2, SRC_DIGA = 4'h3, SRC_DIGB = 4'h4,
        SRC_PRI = 4'h5, SRC_PRI2 = 4'h6, SRC_SEC = 4'h7, SRC_SECREF = 4'h8
    } ocfs_src_t;

    // primary apll frequency in kHz
    function automatic logic [KHZ_W-1:0] ocfsPriKhz(input logic [2:0] code);
        unique case (code)
            3'h0, 3'h1: ocfsPriKhz = 19'd311040;
            3'h2: ocfsPriKhz = 19'd98304;
            3'h3: ocfsPriKhz = 19'd131072;
            3'h4: ocfsPriKhz = 19'd148224;
            3'h5: ocfsPriKhz = 19'd98816;
            3'h6: ocfsPriKhz = 19'd100992;
            default: ocfsPriKhz = 19'd250000;
        endcase
    endfunction

    // secondary apll frequency when running on its own
    function automatic logic [KHZ_W-1:0] ocfsSecKhz(input logic [3:0] code);
        case (code)
            4'h1: ocfsSecKhz = 19'd311040;
            4'h2: ocfsSecKhz = 19'd98304;
            4'h3: ocfsSecKhz = 19'd131072;
            4'h4: ocfsSecKhz = 19'd148224;
            4'h5: ocfsSecKhz = 19'd98816;
            4'h6: ocfsSecKhz = 19'd274944;
            4'h7: ocfsSecKhz = 19'd178944;
            4'h8: ocfsSecKhz = 19'd100992;
            4'h9: ocfsSecKhz = 19'd250000;
            4'hA: ocfsSecKhz = 19'd122880;
            4'hB: ocfsSecKhz = 19'd160000;
            4'hC: ocfsSecKhz = 19'd104000;
            default: ocfsSecKhz = 19'd0;
        endcase
    endfunction

    // secondary apll frequency when locked to the primary dpll
    function automatic logic [KHZ_W-1:0] ocfsLockedKhz(input logic [2:0] code);
        case (code)
            3'h0: ocfsLockedKhz = 19'd98304;
            3'h1: ocfsLockedKhz = 19'd250000;
            3'h2: ocfsLockedKhz = 19'd131072;
            3'h4: ocfsLockedKhz = 19'd148224;
            3'h6: ocfsLockedKhz = 19'd98816;
            3'h7: ocfsLockedKhz = 19'd100992;
            default: ocfsLockedKhz = 19'd0;
        endcase
    endfunction

    // e1 or ds1 family, doubled per code step
    function automatic logic [KHZ_W-1:0] ocfsDigKhz(input logic [1:0] code, input logic std);
        ocfsDigKhz = (std ? 19'd1544 : 19'd2048) << code;
    endfunction

    // second digital clock, alternate table on top of the family
    function automatic logic [KHZ_W-1:0] ocfsDigBKhz(input logic [1:0] code, input logic std, input logic alt);
        if (!alt) begin
            ocfsDigBKhz = ocfsDigKhz(code, std);
        end else begin
            case ({code, std})
                3'b000: ocfsDigBKhz = 19'd6312;
                3'b100: ocfsDigBKhz = 19'd10000;
                3'b001: ocfsDigBKhz = 19'd19440;
                3'b011: ocfsDigBKhz = 19'd38880;
                default: ocfsDigBKhz = 19'd0;
            endcase
        end
    endfunction
endpackage

/* ocfs_out_map.sv */
// Purpose: maps one output's frequency code and alternate bit to a source, divider and enable
// Assumes: IDX selects the per-output column of the selection table
// Notes: results are registered
`timescale 1ns/100ps
`default_nettype none
module ocfs_out_map #(parameter int IDX = 0) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // selection
    input wire logic [3:0] code,
    input wire logic alt,
    input wire logic secOff,
    // result
    output var ocfs_pkg::ocfs_src_t src,
    output logic [ocfs_pkg::DIV_W-1:0] div,
    output logic on
);
    import ocfs_pkg::*;
    localparam bit LOWG = (IDX < 3);
    localparam bit MIDG = (IDX == 3) || (IDX == 4);
    ocfs_src_t srcD;
    logic [DIV_W-1:0] divD;

    // selection table decode, per output column
    always_comb begin
        srcD = SRC_OFF;
        divD = 7'd1;
        if (!alt) begin
            unique case (code)
                4'h0: srcD = SRC_OFF;
                4'h1: srcD = SRC_2K;
                4'h2: srcD = SRC_8K;
                4'h3: begin srcD = (IDX == 5) ? SRC_PRI : SRC_DIGB; divD = (IDX == 5) ? 7'd2 : 7'd1; end
                4'h4: begin srcD = (IDX == 6) ? SRC_PRI : SRC_DIGA; divD = (IDX == 6) ? 7'd2 : 7'd1; end
                4'h5: begin srcD = SRC_PRI; divD = (IDX == 5) ? 7'd1 : 7'd48; end
                4'h6: begin srcD = SRC_PRI; divD = 7'd16; end
                4'h7: begin srcD = SRC_PRI; divD = 7'd12; end
                4'h8: begin srcD = SRC_PRI; divD = 7'd8; end
                4'h9: begin srcD = SRC_PRI; divD = 7'd6; end
                4'hA: begin srcD = SRC_PRI; divD = 7'd4; end
                4'hB: begin srcD = SRC_SEC; divD = MIDG ? 7'd2 : 7'd64; end
                4'hC: begin srcD = SRC_SEC; divD = 7'd48; end
                4'hD: begin srcD = SRC_SEC; divD = 7'd16; end
                4'hE: begin srcD = SRC_SEC; divD = 7'd8; end
                4'hF: begin srcD = SRC_SEC; divD = 7'd4; end
            endcase
        end else begin
            case (code)
                4'h1: begin srcD = (LOWG || MIDG) ? SRC_PRI : SRC_SEC; divD = LOWG ? 7'd64 : (MIDG ? 7'd2 : 7'd5); end
                4'h2: begin srcD = MIDG ? SRC_PRI : SRC_SEC; divD = LOWG ? 7'd20 : (MIDG ? 7'd1 : 7'd2); end
                4'h3: begin srcD = SRC_SEC; divD = LOWG ? 7'd12 : (MIDG ? 7'd10 : 7'd1); end
                4'h4: begin srcD = LOWG ? SRC_SEC : SRC_PRI2; divD = (LOWG || MIDG) ? 7'd10 : 7'd5; end
                4'h5: begin
                    srcD = (IDX == 0 || IDX > 2) ? SRC_PRI2 : SRC_SEC;
                    divD = (IDX == 0) ? 7'd10 : (LOWG ? 7'd5 : 7'd2);
                end
                4'h6: begin
                    srcD = (IDX == 0 || IDX > 2) ? SRC_PRI2 : SRC_SEC;
                    divD = (IDX == 0) ? 7'd5 : (LOWG ? 7'd2 : 7'd1);
                end
                4'h7: srcD = SRC_SECREF;
                default: srcD = SRC_OFF; // disabled and unused codes
            endcase
        end
    end

    // registered result; outputs fed by a powered-down secondary apll are held low
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            src <= SRC_OFF;
            div <= 7'd1;
            on <= 1'b0;
        end else begin
            src <= srcD; // [RQ8]
            div <= divD; // [RQ9]
            on <= (srcD != SRC_OFF) && !(secOff && srcD == SRC_SEC); // [RQ13]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstN);
    offCode_a: assert property ((code == 4'h0) |=> !on) // [RQ8]
        else $error("zero code left output on");
    divSet_a: assert property ( // [RQ9]
        div inside {7'd1, 7'd2, 7'd4, 7'd5, 7'd6, 7'd8, 7'd10, 7'd12, 7'd16, 7'd20, 7'd48, 7'd64})
        else $error("divider ratio outside the allowed set");
    secDown_a: assert property ((secOff && srcD == SRC_SEC) |=> (src == SRC_SEC && !on)) // [RQ13]
        else $error("output on a powered-down apll not held low");
endmodule
`default_nettype wire

/* ocfs_output_clock_freq_select.sv */
// Purpose: APB-programmed frequency plan for the apll paths, digital clocks and seven outputs
// Assumes: zero-wait APB slave, answer in the first access cycle
// Notes: frequencies are reported in kHz; outputs report source, divider and enable
// How it works
// (RQ1) lock select 0 runs secondary apll alone; 1 locks it to primary dpll.
// (RQ2) each apll holds exactly one frequency, outputs divide it by fixed ratios.
// (RQ3) software picks the primary apll frequency before programming output selections.
// (RQ4) primary code: 000/001 311.04, then 98.304,131.072,148.224,98.816,100.992,250 MHz.
// (RQ5) primary synthesis stage runs at a quarter of the primary apll frequency.
// (RQ6) software sets the secondary frequency field when the secondary path runs alone.
// (RQ7) locked secondary needs software to program lock select and locked-mode field.
// (RQ8) each output's frequency comes from its own code plus its alternate-table bit.
// (RQ9) output dividers are limited to 2,4,5,6,8,10,12,16,20,48,64; the code also uses a ratio of 1.
// (RQ10) first digital clock: e1 family 2.048 up, ds1 family 1.544 up.
// (RQ11) second digital clock follows first, alternate gives 6.312,10,19.44,38.88 MHz.
// (RQ12) software order: lock mode, apll frequencies, then output codes and alternate bits.
// (RQ13) secondary code 0000 unlocked powers secondary apll down, its outputs held low.
// (RQ14) second primary apll always runs at 312.5 MHz, never selectable.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ocfs_output_clock_freq_select (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // apll plan
    output logic [ocfs_pkg::KHZ_W-1:0] priApllKhz,
    output logic [ocfs_pkg::KHZ_W-1:0] priDfsKhz,
    output logic [ocfs_pkg::KHZ_W-1:0] pri2ApllKhz,
    output logic [ocfs_pkg::KHZ_W-1:0] secApllKhz,
    output logic secApllOn,
    output logic secLocked,
    // digital clocks
    output logic [ocfs_pkg::KHZ_W-1:0] digAKhz,
    output logic [ocfs_pkg::KHZ_W-1:0] digBKhz,
    // output clocks
    output var ocfs_pkg::ocfs_src_t outSrc [ocfs_pkg::NUM_OUT],
    output logic [ocfs_pkg::DIV_W-1:0] outDiv [ocfs_pkg::NUM_OUT],
    output logic [ocfs_pkg::NUM_OUT-1:0] outOn
);
    import ocfs_pkg::*;
    logic rstMeta_q, rstN;
    logic [6:0] priCtrl_q;
    logic [3:0] secCtrl_q;
    logic [7:0] outCtrl_q [4];
    logic [6:0] outAlt_q;
    logic [2:0] miscSix_q;
    logic [3:0] miscSeven_q;
    logic [31:0] rdData;
    logic rdHit, setup, wrEn, lockSel, secOff;
    logic [2:0] priFreq, lockedFreq;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstN <= rstMeta_q;
        end
    end

    assign setup = psel && !penable;
    assign wrEn = psel && penable && pwrite && pready;
    assign priFreq = priCtrl_q[PRI_FREQ_LSB +: 3];
    assign lockSel = priCtrl_q[LOCK_SEL_BIT];
    assign lockedFreq = priCtrl_q[LOCKED_FREQ_LSB +: 3];
    assign secOff = !lockSel && (secCtrl_q == 4'h0); // [RQ13]

    // register writes at the access edge
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            priCtrl_q <= RST_CFG[6:0];
            secCtrl_q <= RST_CFG[3:0];
            outCtrl_q <= '{default: RST_CFG};
            outAlt_q <= RST_CFG[6:0];
            miscSix_q <= RST_CFG[2:0];
            miscSeven_q <= RST_CFG[3:0];
        end else if (wrEn) begin
            case (paddr)
                ADDR_PRI_CTRL: priCtrl_q <= pwdata[6:0];
                ADDR_SEC_CTRL: secCtrl_q <= pwdata[3:0];
                ADDR_OUT_ALT: outAlt_q <= pwdata[6:0];
                ADDR_MISC_SIX: miscSix_q <= pwdata[2:0];
                ADDR_MISC_SEVEN: miscSeven_q <= pwdata[3:0];
                default: begin
                    for (int k = 0; k < 4; k++) begin
                        if (paddr == ADDR_OUT_CTRL0 + 8'(4 * k)) begin
                            outCtrl_q[k] <= pwdata[7:0];
                        end
                    end
                end
            endcase
        end
    end

    // read decode; unmapped addresses answer with an error and zero data
    always_comb begin
        rdData = 32'h0000_0000;
        rdHit = 1'b1;
        case (paddr)
            ADDR_PRI_CTRL: rdData = {25'h0, priCtrl_q};
            ADDR_SEC_CTRL: rdData = {28'h0, secCtrl_q};
            ADDR_OUT_ALT: rdData = {25'h0, outAlt_q};
            ADDR_MISC_SIX: rdData = {29'h0, miscSix_q};
            ADDR_MISC_SEVEN: rdData = {28'h0, miscSeven_q};
            ADDR_PRI_STAT: rdData = {13'h0, priApllKhz};
            ADDR_SEC_STAT: rdData = {secApllOn, secLocked, 11'h0, secApllKhz};
            default: begin
                rdHit = 1'b0;
                for (int k = 0; k < 4; k++) begin
                    if (paddr == ADDR_OUT_CTRL0 + 8'(4 * k)) begin
                        rdData = {24'h0, outCtrl_q[k]};
                        rdHit = 1'b1;
                    end
                end
            end
        endcase
    end

    // apb answer, ready through the access cycle that follows setup
    // a write commits on the edge that drops pready; derived outputs follow one edge later
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !rdHit;
            prdata <= (setup && !pwrite) ? rdData : 32'h0000_0000;
        end
    end

    // apll frequencies, one set per apll
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            priApllKhz <= '0;
            priDfsKhz <= '0;
            pri2ApllKhz <= '0;
            secApllKhz <= '0;
            secApllOn <= 1'b0;
            secLocked <= 1'b0;
        end else begin
            priApllKhz <= ocfsPriKhz(priFreq); // [RQ4] [RQ2]
            priDfsKhz <= ocfsPriKhz(priFreq) >> DFS_SHIFT; // [RQ5]
            pri2ApllKhz <= SECOND_PRI_KHZ; // [RQ14]
            secLocked <= lockSel; // [RQ1]
            secApllOn <= !secOff; // [RQ13]
            secApllKhz <= lockSel ? ocfsLockedKhz(lockedFreq) : ocfsSecKhz(secCtrl_q); // [RQ1] [RQ2]
        end
    end

    // digital clock frequencies
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            digAKhz <= '0;
            digBKhz <= '0;
        end else begin
            digAKhz <= ocfsDigKhz(miscSeven_q[DIGA_FREQ_LSB +: 2], miscSix_q[DIGA_STD_BIT]); // [RQ10]
            digBKhz <= ocfsDigBKhz(miscSeven_q[DIGB_FREQ_LSB +: 2], miscSix_q[DIGB_STD_BIT],
                miscSix_q[DIGB_ALT_BIT]); // [RQ11]
        end
    end

    // one selector per output clock, code nibbles packed two per word
    for (genvar i = 0; i < NUM_OUT; i++) begin : gOut
        ocfs_out_map #(.IDX(i)) uMap (
            .clk(ref_clk),
            .rstN(rstN),
            .code(outCtrl_q[i / 2][(i % 2) * 4 +: 4]),
            .alt(outAlt_q[i]),
            .secOff(secOff),
            .src(outSrc[i]),
            .div(outDiv[i]),
            .on(outOn[i])
        ); // [RQ8]
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstN);
    // checks on the frequency plan and on the bus answer
    lockFollow_a: assert property ( // [RQ1]
        (lockSel && lockedFreq == 3'h1) |=> (secLocked && secApllKhz == 19'd250000))
        else $error("locked secondary not at locked-mode frequency");
    lockOn_a: assert property (lockSel |=> (secLocked && secApllOn)) // [RQ1]
        else $error("locked secondary not powered");
    oneSet_a: assert property ( // [RQ2]
        $past(rstN) && $stable(priCtrl_q) && $stable(secCtrl_q) |=> $stable(secApllKhz))
        else $error("apll frequency moved with steady settings");
    priCode_a: assert property ((priFreq == 3'h6) |=> priApllKhz == 19'd100992) // [RQ4]
        else $error("primary frequency code decoded wrongly");
    priQuarter_a: assert property ($past(rstN) |-> ({priDfsKhz, 2'b00} == {2'b00, priApllKhz})) // [RQ5]
        else $error("synthesis stage not a quarter of the apll");
    digA_a: assert property ((miscSeven_q[1:0] == 2'b11 && miscSix_q[0]) |=> digAKhz == 19'd12352) // [RQ10]
        else $error("first digital clock decode wrong");
    digB_a: assert property ( // [RQ11]
        (miscSix_q[2:1] == 2'b11 && miscSeven_q[3:2] == 2'b01) |=> digBKhz == 19'd38880)
        else $error("second digital clock alternate decode wrong");
    secPowerDown_a: assert property (secOff |=> (!secApllOn && secApllKhz == 19'd0)) // [RQ13]
        else $error("secondary apll not powered down");
    fixedPri2_a: assert property ($past(rstN) |-> pri2ApllKhz == 19'd312500) // [RQ14]
        else $error("second primary apll not fixed");
    apbAnswer_a: assert property (setup |=> pready ##1 !pready)
        else $error("apb answer not one access cycle");
    errData_a: assert property (pslverr |-> (pready && prdata == 32'h0000_0000))
        else $error("error answer without ready or with data");
    lockedCov_c: cover property (lockSel ##1 secLocked);
    powerDownCov_c: cover property (secOff ##1 !secApllOn);
    pri2Cov_c: cover property (outOn[3] && outSrc[3] == SRC_PRI2);
    errCov_c: cover property (pready && pslverr);
    digAltCov_c: cover property (miscSix_q[2] && digBKhz == 19'd10000);
endmodule
`default_nettype wire

/* ocfs_output_clock_freq_select_tb_top.sv */
// Purpose: self-checking bench for the output clock frequency selector
// Assumes: zero-wait APB slave; derived outputs settle one edge after a register commit
// Notes: expected frequencies come from tables kept here, in kHz; random values from an lfsr
`timescale 1ns/100ps
`default_nettype none
module ocfs_output_clock_freq_select_tb_top;
    import ocfs_pkg::*;
    // expected apll frequencies in kHz, indexed by field code
    localparam logic [18:0] PRI_T [8] = '{19'h4BF00, 19'h4BF00, 19'h18000, 19'h20000, 19'h24300, 19'h18200,
        19'h18A80, 19'h3D090};
    localparam logic [18:0] SEC_T [16] = '{19'h0, 19'h4BF00, 19'h18000, 19'h20000, 19'h24300, 19'h18200,
        19'h43200, 19'h2BB00, 19'h18A80, 19'h3D090, 19'h1E000, 19'h27100, 19'h19640, 19'h0, 19'h0, 19'h0};
    localparam logic [18:0] LCK_T [8] = '{19'h18000, 19'h3D090, 19'h20000, 19'h0, 19'h24300, 19'h0,
        19'h18200, 19'h18A80};
    // second digital clock alternate table, indexed by {code, std}
    localparam logic [18:0] DBA_T [8] = '{19'h18A8, 19'h4BF0, 19'h0, 19'h97E0, 19'h2710, 19'h0, 19'h0, 19'h0};
    // first output column, indexed by {alt, code}
    localparam logic [3:0] SRC0 [32] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h3, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5,
        4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h0, 4'h5, 4'h7, 4'h7, 4'h7, 4'h6, 4'h6, 4'h8,
        4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    localparam logic [6:0] DIV0 [32] = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h30, 7'h10, 7'h0C, 7'h08, 7'h06,
        7'h04, 7'h40, 7'h30, 7'h10, 7'h08, 7'h04, 7'h01, 7'h40, 7'h14, 7'h0C, 7'h0A, 7'h0A, 7'h05, 7'h01,
        7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h01};
    logic ref_clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [KHZ_W-1:0] priApllKhz;
    logic [KHZ_W-1:0] priDfsKhz;
    logic [KHZ_W-1:0] pri2ApllKhz;
    logic [KHZ_W-1:0] secApllKhz;
    logic secApllOn;
    logic secLocked;
    logic [KHZ_W-1:0] digAKhz;
    logic [KHZ_W-1:0] digBKhz;
    ocfs_src_t outSrc [NUM_OUT];
    logic [DIV_W-1:0] outDiv [NUM_OUT];
    logic [NUM_OUT-1:0] outOn;
    logic [31:0] seed;
    int errorCnt;
    int nChecks;

    ocfs_output_clock_freq_select dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .priApllKhz(priApllKhz), .priDfsKhz(priDfsKhz), .pri2ApllKhz(pri2ApllKhz), .secApllKhz(secApllKhz),
        .secApllOn(secApllOn), .secLocked(secLocked), .digAKhz(digAKhz), .digBKhz(digBKhz),
        .outSrc(outSrc), .outDiv(outDiv), .outOn(outOn));

    // 40 ns clock
    always #20 ref_clk = ~ref_clk;

    // verdict and end of run
    task automatic stopTest();
        $display("checks %0d, mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // galois-free shift register, 32 bits
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // one APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) begin
            errorCnt++;
            $display("unexpected pready: expected 1, seen 0");
            stopTest();
        end
    endtask

    // write, then let derived outputs settle
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        chk("write error", 32'h0, 32'(err));
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        logic [31:0] rd;
        logic [31:0] w [4];
        logic [31:0] altw;
        logic err;
        logic [3:0] cd;
        logic [18:0] e;
        ref_clk = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'h000108B6;
        errorCnt = 0;
        nChecks = 0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        // reset plan and zeroed registers
        chk("priApllKhz", 32'h4BF00, 32'(priApllKhz));
        chk("priDfsKhz", 32'h12FC0, 32'(priDfsKhz));
        chk("pri2ApllKhz", 32'h4C4B4, 32'(pri2ApllKhz));
        chk("secApllOn", 32'h0, 32'(secApllOn));
        chk("outOn", 32'h0, 32'(outOn));
        for (int a = 0; a < 9; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0, rd, err);
            chk("reset register", 32'h0, rd);
        end
        $display("test reset done");
        // primary frequency codes, lock mode left independent first
        for (int c = 0; c < 8; c++) begin
            wreg(ADDR_PRI_CTRL, 32'(c));
            chk("priApllKhz", 32'(PRI_T[c]), 32'(priApllKhz));
            chk("priDfsKhz", 32'(PRI_T[c] >> 2), 32'(priDfsKhz));
            chk("pri2ApllKhz", 32'h4C4B4, 32'(pri2ApllKhz));
            apb(1'b0, ADDR_PRI_STAT, 32'h0, rd, err);
            chk("primary status", 32'(PRI_T[c]), rd);
        end
        $display("test primary done");
        // independent secondary, every code
        for (int c = 0; c < 16; c++) begin
            wreg(ADDR_SEC_CTRL, 32'(c));
            chk("secApllKhz", 32'(SEC_T[c]), 32'(secApllKhz));
            chk("secApllOn", 32'(c != 0), 32'(secApllOn));
            apb(1'b0, ADDR_SEC_STAT, 32'h0, rd, err);
            chk("secondary status", {c != 0, 12'h0, SEC_T[c]}, rd);
        end
        // locked secondary with its own code at zero, so it must not power down
        wreg(ADDR_SEC_CTRL, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wreg(ADDR_PRI_CTRL, 32'((c << 4) | 8));
            chk("locked secApllKhz", 32'(LCK_T[c]), 32'(secApllKhz));
            chk("secLocked", 32'h1, 32'(secLocked));
            chk("locked secApllOn", 32'h1, 32'(secApllOn));
        end
        $display("test secondary done");
        // digital clocks, every combination
        for (int i = 0; i < 128; i++) begin
            wreg(ADDR_MISC_SIX, 32'(i & 7));
            wreg(ADDR_MISC_SEVEN, 32'(i >> 3));
            e = (i[0] ? 19'h608 : 19'h800) << i[4:3];
            chk("digAKhz", 32'(e), 32'(digAKhz));
            e = i[2] ? DBA_T[{i[6:5], i[1]}] : ((i[1] ? 19'h608 : 19'h800) << i[6:5]);
            chk("digBKhz", 32'(e), 32'(digBKhz));
        end
        $display("test digital done");
        // outputs: first column exhaustive, the rest random
        wreg(ADDR_PRI_CTRL, 32'h0);
        wreg(ADDR_SEC_CTRL, 32'h1);
        for (int i = 0; i < 32; i++) begin
            for (int j = 0; j < 4; j++) begin
                seed = lfsrNext(seed);
                w[j] = seed;
            end
            w[0][3:0] = 4'(i);
            altw = {w[1][31:1], i[4]};
            for (int j = 0; j < 4; j++) wreg(8'(ADDR_OUT_CTRL0 + j * 4), w[j]);
            wreg(ADDR_OUT_ALT, altw);
            chk("outSrc0", 32'(SRC0[i]), 32'(outSrc[0]));
            chk("outDiv0", 32'(DIV0[i]), 32'(outDiv[0]));
            chk("outOn0", 32'(SRC0[i] != 4'h0), 32'(outOn[0]));
            for (int j = 1; j < NUM_OUT; j++) begin
                cd = w[j / 2][(j % 2) * 4 +: 4];
                chk("outDiv set", 32'h1, 32'(outDiv[j] inside {1, 2, 4, 5, 6, 8, 10, 12, 16, 20, 48, 64}));
                if (cd == 4'h0) chk("outOn off", 32'h0, 32'(outOn[j]));
            end
        end
        // secondary powered down holds its outputs low; the fourth output divides by 2
        wreg(ADDR_OUT_ALT, 32'h0);
        wreg(ADDR_OUT_CTRL0, 32'h5B);
        wreg(8'(ADDR_OUT_CTRL0 + 4), 32'hB0);
        chk("outDiv3", 32'h2, 32'(outDiv[3]));
        wreg(ADDR_SEC_CTRL, 32'h0);
        chk("outOn secOff", 32'h2, 32'(outOn[1:0]));
        wreg(ADDR_PRI_CTRL, 32'h8);
        chk("outOn locked", 32'h3, 32'(outOn[1:0]));
        // column-specific entries on the remaining outputs
        wreg(8'(ADDR_OUT_CTRL0 + 8), 32'h33);
        wreg(8'(ADDR_OUT_CTRL0 + 12), 32'h04);
        chk("outSrc1", 32'(SRC_PRI), 32'(outSrc[1]));
        chk("outDiv1", 32'h30, 32'(outDiv[1]));
        chk("outSrc3", 32'(SRC_SEC), 32'(outSrc[3]));
        chk("outSrc4", 32'(SRC_DIGB), 32'(outSrc[4]));
        chk("outSrc5", 32'(SRC_PRI), 32'(outSrc[5]));
        chk("outDiv5", 32'h2, 32'(outDiv[5]));
        chk("outSrc6", 32'(SRC_PRI), 32'(outSrc[6]));
        chk("outDiv6", 32'h2, 32'(outDiv[6]));
        wreg(ADDR_OUT_ALT, 32'h7F);
        chk("outSrc6 alt", 32'(SRC_PRI2), 32'(outSrc[6]));
        chk("outDiv4 alt", 32'hA, 32'(outDiv[4]));
        $display("test outputs done");
        // unmapped and read-only places
        apb(1'b0, 8'h40, 32'h0, rd, err);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 8'h40, 32'hFFFFFFFF, rd, err);
        chk("unmapped write error", 32'h1, 32'(err));
        wreg(ADDR_PRI_STAT, 32'hFFFFFFFF);
        apb(1'b0, ADDR_PRI_STAT, 32'h0, rd, err);
        chk("status kept", 32'h4BF00, rd);
        apb(1'b0, ADDR_PRI_CTRL, 32'h0, rd, err);
        chk("primary control kept", 32'h8, rd);
        $display("test access done");
        stopTest();
    end
endmodule
`default_nettype wire
